/* common/tsrb_pkg.sv */
// ============================================================
// shared constants and types of the thermal register bank
package tsrb_pkg;
   // register selector values
   localparam logic [1:0] SEL_READING = 2'h0;
   localparam logic [1:0] SEL_SETUP   = 2'h1;
   localparam logic [1:0] SEL_HYST    = 2'h2;
   localparam logic [1:0] SEL_OVERHT  = 2'h3;
   // reset values
   localparam logic [1:0]  SEL_RST    = 2'h0;
   localparam logic [7:0]  SETUP_RST  = 8'h00;
   localparam logic [15:0] HYST_RST   = 16'h4B00;
   localparam logic [15:0] OVERHT_RST = 16'h5000;
   // setup register field positions
   localparam int SETUP_SHUTDOWN = 0;
   localparam int SETUP_MODE     = 1;
   localparam int SETUP_POL      = 2;
   localparam int SETUP_FQ_LO    = 3;
   localparam int SETUP_FQ_HI    = 4;
   // fixed upper part of the 7-bit bus address
   localparam logic [3:0] ADDR_HI = 4'h9;
   // byte position inside one bus transaction
   localparam logic [1:0] BI_ADDR = 2'h0;
   localparam logic [1:0] BI_SEL  = 2'h1;
   localparam logic [1:0] BI_D0   = 2'h2;
   localparam logic [1:0] BI_D1   = 2'h3;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX   = 5'h02,
      ST_ACK  = 5'h04,
      ST_TX   = 5'h08,
      ST_MACK = 5'h10
   } tsrb_fsm_t;

   // complete state of the register bank
   typedef struct packed {
      logic        scl_s1, scl_s2, scl_d;
      logic        sda_s1, sda_s2, sda_d;
      logic [2:0]  adr_s1, adr_s2;
      tsrb_fsm_t   fsm;
      logic [3:0]  bitcnt;
      logic [7:0]  sh;
      logic [1:0]  byte_idx;
      logic        rw;
      logic        tx_lsb;
      logic [1:0]  sel;
      logic [7:0]  msb_hold;
      logic [7:0]  setup;
      logic [10:0] reading;
      logic [8:0]  overht;
      logic [8:0]  hyst;
      logic        alert_act;
      logic        arm_hi;
      logic [2:0]  fault_cnt;
      logic        sda_oe;
      logic        alert_oe;
      logic        conv_en;
   } tsrb_state_t;
endpackage

/* design/tsrb_bank.sv */
`timescale 1ns/1ps
// How it works
// - low selector bits pick one of four registers
// - selector upper six bits held at zero
// - selector latched per command, kept for rereads
// - selector resets to temperature reading
// - selector never readable, loaded by selector byte
// - setup byte read/write at 01h, reset 00h
// - reading register read-only, holds latest result
// - overheat limit read/write, resets 5000h
// - hysteresis limit read/write, resets 4B00h
// - setup bits 7..5 stored, default zero
// - fault queue depth 1, 2, 4, 6
// - setup bit 2 sets alert polarity
// - setup bit 1 picks comparator or interrupt
// - setup bit 0 selects shutdown
// - interrupt alert cleared by read or shutdown
// - shutdown stops conversions, reading holds value
// - compare only nine upper reading bits
// - alert needs configured consecutive fault count
module tsrb_bank (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [2:0]  addr_pins,
   input  wire logic [10:0] sample_data,
   input  wire logic        sample_valid,
   output logic             conv_enable,
   output logic             alert_output_out,
   output logic             alert_output_oe
);
   tsrb_pkg::tsrb_state_t st_r, st_nxt;

   // fault queue depth from the two setup bits
   function automatic logic [2:0] qdepth(input logic [1:0] code);
      case (code)
         2'h0:    qdepth = 3'h1;
         2'h1:    qdepth = 3'h2;
         2'h2:    qdepth = 3'h4;
         default: qdepth = 3'h6;
      endcase
   endfunction

   // byte presented to the bus for the selected register, high byte first
   function automatic logic [7:0] rd_byte(input tsrb_pkg::tsrb_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      case (s.sel)
         tsrb_pkg::SEL_READING: w = {s.reading, 5'h00};
         tsrb_pkg::SEL_SETUP:   w = {s.setup, s.setup};
         tsrb_pkg::SEL_HYST:    w = {s.hyst, 7'h00};
         default:               w = {s.overht, 7'h00};
      endcase
      rd_byte = s.tx_lsb ? w[7:0] : w[15:8];
   endfunction

   logic       scl_rise, scl_fall, bus_start, bus_stop;
   logic       over, under, cond, read_hit, sd_entry;
   logic [2:0] depth;
   logic [7:0] nb;

   // ============================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      nb = 8'h00;
      read_hit = 1'b0;
      sd_entry = 1'b0;
      // pins pass two flops; edge logic compares the second stage with a third, delayed copy
      st_nxt.scl_s1 = scl_in;
      st_nxt.scl_s2 = st_r.scl_s1;
      st_nxt.scl_d  = st_r.scl_s2;
      st_nxt.sda_s1 = sda_in;
      st_nxt.sda_s2 = st_r.sda_s1;
      st_nxt.sda_d  = st_r.sda_s2;
      st_nxt.adr_s1 = addr_pins;
      st_nxt.adr_s2 = st_r.adr_s1;
      scl_rise  = st_r.scl_s2 & ~st_r.scl_d;
      scl_fall  = ~st_r.scl_s2 & st_r.scl_d;
      bus_start = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
      bus_stop  = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;

      // bus engine: sample on rising scl, drive on falling scl
      if (bus_start) begin
         st_nxt.fsm      = tsrb_pkg::ST_RX;
         st_nxt.bitcnt   = 4'h0;
         st_nxt.byte_idx = tsrb_pkg::BI_ADDR;
         st_nxt.sda_oe   = 1'b0;
      end else if (bus_stop) begin
         st_nxt.fsm    = tsrb_pkg::ST_IDLE;
         st_nxt.sda_oe = 1'b0;
      end else begin
         case (st_r.fsm)
            tsrb_pkg::ST_IDLE: begin
               st_nxt.sda_oe = 1'b0;
            end
            tsrb_pkg::ST_RX: begin
               if (scl_rise) begin
                  st_nxt.sh     = {st_r.sh[6:0], st_r.sda_s2};
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               end else if (scl_fall && st_r.bitcnt == tsrb_pkg::BITS_PER_BYTE) begin
                  st_nxt.fsm    = tsrb_pkg::ST_ACK;
                  st_nxt.sda_oe = 1'b1;
                  if (st_r.byte_idx != tsrb_pkg::BI_D1)
                     st_nxt.byte_idx = st_r.byte_idx + 2'h1;
                  case (st_r.byte_idx)
                     tsrb_pkg::BI_ADDR: begin
                        if (st_r.sh[7:1] == {tsrb_pkg::ADDR_HI, st_r.adr_s2}) begin
                           st_nxt.rw     = st_r.sh[0];
                           st_nxt.tx_lsb = 1'b0;
                           read_hit      = st_r.sh[0];
                        end else begin
                           st_nxt.fsm    = tsrb_pkg::ST_IDLE;  // not our address: stay silent
                           st_nxt.sda_oe = 1'b0;
                        end
                     end
                     tsrb_pkg::BI_SEL: begin
                        st_nxt.sel = st_r.sh[1:0];  // upper bits dropped, never stored
                     end
                     tsrb_pkg::BI_D0: begin
                        st_nxt.msb_hold = st_r.sh;  // high byte first
                        if (st_r.sel == tsrb_pkg::SEL_SETUP) begin
                           st_nxt.setup = st_r.sh;  // all eight bits kept
                           sd_entry = st_r.sh[tsrb_pkg::SETUP_SHUTDOWN] & ~st_r.setup[tsrb_pkg::SETUP_SHUTDOWN];
                        end
                     end
                     default: begin
                        // low byte commits the pair; reading register ignores writes
                        if (st_r.sel == tsrb_pkg::SEL_HYST)
                           st_nxt.hyst = {st_r.msb_hold, st_r.sh[7]};
                        else if (st_r.sel == tsrb_pkg::SEL_OVERHT)
                           st_nxt.overht = {st_r.msb_hold, st_r.sh[7]};
                     end
                  endcase
               end
            end
            tsrb_pkg::ST_ACK: begin
               if (scl_fall) begin
                  st_nxt.bitcnt = 4'h0;
                  if (st_r.rw) begin
                     nb = rd_byte(st_r);
                     st_nxt.fsm    = tsrb_pkg::ST_TX;
                     st_nxt.sh     = nb;
                     st_nxt.sda_oe = ~nb[7];
                  end else begin
                     st_nxt.fsm    = tsrb_pkg::ST_RX;
                     st_nxt.sda_oe = 1'b0;
                  end
               end
            end
            tsrb_pkg::ST_TX: begin
               if (scl_rise)
                  st_nxt.bitcnt = st_r.bitcnt + 4'h1;
               else if (scl_fall) begin
                  if (st_r.bitcnt == tsrb_pkg::BITS_PER_BYTE) begin
                     st_nxt.fsm    = tsrb_pkg::ST_MACK;
                     st_nxt.sda_oe = 1'b0;
                  end else begin
                     st_nxt.sh     = {st_r.sh[6:0], 1'b0};
                     st_nxt.sda_oe = ~st_r.sh[6];
                  end
               end
            end
            tsrb_pkg::ST_MACK: begin
               // controller ack asks for the next byte, nack ends the read
               if (scl_rise && st_r.sda_s2)
                  st_nxt.fsm = tsrb_pkg::ST_IDLE;
               else if (scl_fall) begin
                  st_nxt.tx_lsb = ~st_r.tx_lsb;
                  nb = rd_byte(st_nxt);
                  st_nxt.fsm    = tsrb_pkg::ST_TX;
                  st_nxt.bitcnt = 4'h0;
                  st_nxt.sh     = nb;
                  st_nxt.sda_oe = ~nb[7];
               end
            end
            default: begin
               st_nxt.fsm    = tsrb_pkg::ST_IDLE;
               st_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // interrupt latch clears first so a same-cycle trip still wins
      if (st_r.setup[tsrb_pkg::SETUP_MODE] && (read_hit || sd_entry))
         st_nxt.alert_act = 1'b0;

      // conversion results; frozen in shutdown
      over  = $signed(sample_data[10:2]) > $signed(st_r.overht);  // nine upper bits only
      under = $signed(sample_data[10:2]) < $signed(st_r.hyst);
      depth = qdepth(st_r.setup[tsrb_pkg::SETUP_FQ_HI:tsrb_pkg::SETUP_FQ_LO]);
      cond  = st_r.setup[tsrb_pkg::SETUP_MODE] ? (st_r.arm_hi ? over : under)
                                               : (st_r.alert_act ? under : over);
      if (sample_valid && st_r.conv_en) begin
         st_nxt.reading = sample_data;
         if (cond) begin
            if (st_r.fault_cnt + 3'h1 >= depth) begin
               st_nxt.fault_cnt = 3'h0;
               if (st_r.setup[tsrb_pkg::SETUP_MODE]) begin
                  st_nxt.alert_act = 1'b1;
                  st_nxt.arm_hi    = ~st_r.arm_hi;
               end else
                  st_nxt.alert_act = ~st_r.alert_act;
            end else
               st_nxt.fault_cnt = st_r.fault_cnt + 3'h1;
         end else
            st_nxt.fault_cnt = 3'h0;
      end

      st_nxt.conv_en = ~st_nxt.setup[tsrb_pkg::SETUP_SHUTDOWN];
      // open drain: pull low whenever the pin level should be low
      st_nxt.alert_oe = st_nxt.setup[tsrb_pkg::SETUP_POL] ? ~st_nxt.alert_act : st_nxt.alert_act;
   end

   // ============================================================
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r           <= '0;
         st_r.scl_s1    <= 1'b1;
         st_r.scl_s2    <= 1'b1;
         st_r.scl_d     <= 1'b1;
         st_r.sda_s1    <= 1'b1;
         st_r.sda_s2    <= 1'b1;
         st_r.sda_d     <= 1'b1;
         st_r.fsm       <= tsrb_pkg::ST_IDLE;
         st_r.sel       <= tsrb_pkg::SEL_RST;
         st_r.setup     <= tsrb_pkg::SETUP_RST;
         st_r.hyst      <= tsrb_pkg::HYST_RST[15:7];
         st_r.overht    <= tsrb_pkg::OVERHT_RST[15:7];
         st_r.arm_hi    <= 1'b1;
         st_r.conv_en   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // output enables straight from flops; the data line is only ever pulled low
   assign sda_out          = 1'b0;
   assign sda_oe           = st_r.sda_oe;
   assign conv_enable      = st_r.conv_en;
   assign alert_output_out = 1'b0;
   assign alert_output_oe  = st_r.alert_oe;

   // ============================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic rx_done, cmd_read;
   assign rx_done  = st_r.fsm == tsrb_pkg::ST_RX && scl_fall && st_r.bitcnt == tsrb_pkg::BITS_PER_BYTE
                     && !bus_start && !bus_stop;
   assign cmd_read = rx_done && st_r.byte_idx == tsrb_pkg::BI_ADDR && st_r.sh[0]
                     && st_r.sh[7:1] == {tsrb_pkg::ADDR_HI, st_r.adr_s2};

   a_sel_latch: assert property (rx_done && st_r.byte_idx == tsrb_pkg::BI_SEL
      |=> st_r.sel == $past(st_r.sh[1:0]) && st_r.fsm == tsrb_pkg::ST_ACK)
      else $error("selector not latched");
   a_setup_write: assert property (rx_done && st_r.byte_idx == tsrb_pkg::BI_D0
      && st_r.sel == tsrb_pkg::SEL_SETUP |=> st_r.setup == $past(st_r.sh))
      else $error("setup byte not stored");
   a_limit_pair: assert property (rx_done && st_r.byte_idx == tsrb_pkg::BI_D1
      && st_r.sel == tsrb_pkg::SEL_OVERHT |=> st_r.overht == {$past(st_r.msb_hold), $past(st_r.sh[7])})
      else $error("overheat limit pair wrong");
   a_reading_load: assert property (sample_valid && st_r.conv_en
      |=> st_r.reading == $past(sample_data))
      else $error("reading not updated");
   a_shutdown_hold: assert property (!st_r.conv_en && !(sample_valid && st_r.conv_en)
      |=> $stable(st_r.reading))
      else $error("reading changed in shutdown");
   a_alert_pol: assert property (st_r.alert_oe
      == (st_r.setup[tsrb_pkg::SETUP_POL] ? ~st_r.alert_act : st_r.alert_act))
      else $error("alert polarity wrong");
   a_read_clear: assert property (cmd_read && st_r.setup[tsrb_pkg::SETUP_MODE] && !sample_valid
      |=> !st_r.alert_act && st_r.alert_oe == st_r.setup[tsrb_pkg::SETUP_POL])
      else $error("interrupt alert not cleared by read");
   a_queue_depth: assert property ($rose(st_r.alert_act)
      |-> $past(st_r.fault_cnt) + 3'h1 >= qdepth($past(st_r.setup[4:3])))
      else $error("alert before fault queue filled");
   // the low limit commits on the low byte just like the high one
   a_hyst_pair: assert property (rx_done && st_r.byte_idx == tsrb_pkg::BI_D1
      && st_r.sel == tsrb_pkg::SEL_HYST |=> st_r.hyst == {$past(st_r.msb_hold), $past(st_r.sh[7])})
      else $error("hysteresis limit pair wrong");
   // entering shutdown in interrupt mode drops the latched alert; no strobe in that cycle
   a_sd_clear: assert property (rx_done && st_r.byte_idx == tsrb_pkg::BI_D0
      && st_r.sel == tsrb_pkg::SEL_SETUP && st_r.sh[tsrb_pkg::SETUP_SHUTDOWN]
      && !st_r.setup[tsrb_pkg::SETUP_SHUTDOWN] && st_r.setup[tsrb_pkg::SETUP_MODE] && !sample_valid
      |=> !st_r.alert_act && !st_r.conv_en)
      else $error("shutdown entry kept interrupt alert");
   // only a selector byte may move the selection
   a_sel_hold: assert property (!(rx_done && st_r.byte_idx == tsrb_pkg::BI_SEL)
      |=> $stable(st_r.sel))
      else $error("selector moved without selector byte");

   c_reg_read: cover property (cmd_read ##[1:400] st_r.fsm == tsrb_pkg::ST_MACK);
   c_limit_write: cover property (rx_done && st_r.byte_idx == tsrb_pkg::BI_D1);
   c_alert_rise: cover property ($rose(st_r.alert_act));
   c_shutdown_entry: cover property (st_r.conv_en ##1 !st_r.conv_en);
   c_int_clear: cover property (st_r.alert_act && st_r.setup[tsrb_pkg::SETUP_MODE] ##1 !st_r.alert_act);
endmodule

/* tb/tsrb_ctrl_model.sv */
`timescale 1ns/1ps
// ============================================================
// bus controller model: owns the clock line, pulls data low, reads the resolved line
module tsrb_ctrl_model (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // quarter bus period; half period of eight system clocks lets the synchroniser keep up
   localparam time Q = 80ns;
   // idle bus: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // one bit: data moves mid low phase, line sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic r);
      #Q sda_pull = ~b;
      #Q scl = 1'b1;
      #(2*Q) r = sda;
      scl = 1'b0;
   endtask
   // start or repeated start: data falls while clock is high
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda_pull = 1'b1;
      #(2*Q) scl = 1'b0;
   endtask
   // stop: data rises while clock is high, then the clock stands still
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_pull = 1'b0;
      #(4*Q);
   endtask
   // byte out msb first, then the acknowledge slot is left to the device
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // byte in msb first; last byte answered with a release so the device stops
   task automatic rd_byte(output logic [7:0] b, input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, r);
   endtask
endmodule

/* tb/tsrb_bank_tb.sv */
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the thermal register bank
module tsrb_bank_tb;
   localparam logic [2:0] STRAPS = 3'h5;
   localparam logic [7:0] DEV_W  = {tsrb_pkg::ADDR_HI, STRAPS, 1'b0};
   typedef struct {
      logic [7:0]  selb;
      int          n;
      logic [15:0] wr;
      logic [15:0] exp;
   } tsrb_row_t;
   logic        clk, rst, scl, ctl_pull, sda, sample_valid;
   logic        sda_out, sda_oe, conv_enable, alert_output_out, alert_output_oe;
   logic [10:0] sample_data;
   logic [15:0] d;
   int          num_errors = 0;
   int          checks = 0;
   // reading first so the last selection is not the reading register
   tsrb_row_t   rows [4] = '{'{8'h00, 2, 16'hFFFF, 16'h0000}, '{8'h01, 1, 16'h00E0, 16'h00E0},
                             '{8'h02, 2, 16'h1234, 16'h1200}, '{8'h03, 2, 16'hFF80, 16'hFF80}};
   // ============================================================
   // open-drain data line with pull-up
   assign sda = ~ctl_pull & (sda_oe ? sda_out : 1'b1);
   tsrb_bank i_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
                    .sda_oe(sda_oe), .addr_pins(STRAPS), .sample_data(sample_data),
                    .sample_valid(sample_valid), .conv_enable(conv_enable),
                    .alert_output_out(alert_output_out), .alert_output_oe(alert_output_oe));
   tsrb_ctrl_model i_ctl (.scl(scl), .sda_pull(ctl_pull), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ============================================================
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic done(input string what);
      $display("test %s finished", what);
   endtask
   // write: selector byte always first, then data bytes
   task automatic wr_reg(input logic [7:0] selb, input int n, input logic [15:0] v);
      logic ack;
      @(posedge clk);
      #1;
      i_ctl.start();
      i_ctl.wr_byte(DEV_W, ack);
      i_ctl.wr_byte(selb, ack);
      if (n == 2) i_ctl.wr_byte(v[15:8], ack);
      if (n > 0) i_ctl.wr_byte(v[7:0], ack);
      i_ctl.stop();
   endtask
   // read, optionally reselecting first with a repeated start
   task automatic rd_reg(input logic set, input logic [7:0] selb, input int n, output logic [15:0] v);
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ack;
      hi = 8'h00;
      @(posedge clk);
      #1;
      if (set) begin
         i_ctl.start();
         i_ctl.wr_byte(DEV_W, ack);
         i_ctl.wr_byte(selb, ack);
      end
      i_ctl.start();
      i_ctl.wr_byte(DEV_W | 8'h01, ack);
      if (n == 2) i_ctl.rd_byte(hi, 1'b0);
      i_ctl.rd_byte(lo, 1'b1);
      i_ctl.stop();
      v = {hi, lo};
   endtask
   // one converter strobe, then time for the alert logic to settle
   task automatic sample(input logic [10:0] v);
      @(posedge clk);
      #1 sample_data = v;
      sample_valid = 1'b1;
      @(posedge clk);
      #1 sample_valid = 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ============================================================
   // watchdog: the whole sequence needs well under a millisecond
   initial begin
      #1500us;
      num_errors++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      sample_data = 11'h000;
      sample_valid = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         wr_reg(rows[i].selb, rows[i].n, rows[i].wr);
         rd_reg(1'b1, rows[i].selb, rows[i].n, d);
         chk("readback", rows[i].exp, d);
      end
      done("table");
      // second reset mid-run; limits were left at odd values on purpose
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      rd_reg(1'b0, 8'h00, 2, d);
      chk("reading after reset", 16'h0000, d);
      rd_reg(1'b1, 8'h01, 1, d);
      chk("setup after reset", 16'h0000, d);
      rd_reg(1'b1, 8'h02, 2, d);
      chk("hysteresis after reset", 16'h4B00, d);
      rd_reg(1'b1, 8'h03, 2, d);
      chk("overheat after reset", 16'h5000, d);
      chk_bit("conversion on", 1'b1, conv_enable);
      chk_bit("alert idle", 1'b0, alert_output_oe);
      chk_bit("alert pin only pulled", 1'b0, alert_output_out);
      done("reset");
      // a selector byte alone picks the register; selection kept across rereads
      wr_reg(8'h02, 0, 16'h0000);
      rd_reg(1'b0, 8'h00, 2, d);
      chk("selector only", 16'h4B00, d);
      rd_reg(1'b0, 8'h00, 2, d);
      chk("selector kept", 16'h4B00, d);
      done("selector");
      // equal in the upper nine bits is no fault, whatever the low two bits say
      sample(11'h283);
      chk_bit("nine-bit compare", 1'b0, alert_output_oe);
      // hot result trips the default active-low alert with a queue of one
      sample(11'h3F8);
      rd_reg(1'b1, 8'h00, 2, d);
      chk("reading", 16'h7F00, d);
      chk_bit("alert active low", 1'b1, alert_output_oe);
      wr_reg(8'h01, 1, 16'h0004);
      chk_bit("alert active high", 1'b0, alert_output_oe);
      sample(11'h000);
      chk_bit("alert returned", 1'b1, alert_output_oe);
      wr_reg(8'h01, 1, 16'h0018);
      repeat (5) sample(11'h3F8);
      chk_bit("queue of six after five", 1'b0, alert_output_oe);
      sample(11'h3F8);
      chk_bit("queue of six after six", 1'b1, alert_output_oe);
      done("alert");
      // interrupt mode: the alert holds until any register read
      wr_reg(8'h01, 1, 16'h001A);
      chk_bit("alert held", 1'b1, alert_output_oe);
      rd_reg(1'b0, 8'h01, 1, d);
      chk("setup", 16'h001A, d);
      chk_bit("read clears alert", 1'b0, alert_output_oe);
      // interrupt trips alternate, over first and then under, with a queue of two
      wr_reg(8'h01, 1, 16'h000A);
      sample(11'h3F8);
      chk_bit("queue of two after one", 1'b0, alert_output_oe);
      sample(11'h3F8);
      chk_bit("over trip", 1'b1, alert_output_oe);
      rd_reg(1'b0, 8'h01, 1, d);
      chk("setup", 16'h000A, d);
      repeat (2) sample(11'h3F8);
      chk_bit("over ignored after over trip", 1'b0, alert_output_oe);
      repeat (2) sample(11'h000);
      chk_bit("under trip", 1'b1, alert_output_oe);
      done("interrupt");
      // shutdown: strobes ignored, last result held, bus still answers
      wr_reg(8'h01, 1, 16'h0001);
      chk_bit("conversion off", 1'b0, conv_enable);
      chk_bit("shutdown clears alert", 1'b0, alert_output_oe);
      sample(11'h001);
      rd_reg(1'b1, 8'h00, 2, d);
      chk("held reading", 16'h0000, d);
      done("shutdown");
      conclude();
   end
endmodule
